// ---- inc/cmfc_consts.vh ----
// Purpose: constants for the CAN mode and filter control block
// Assumes: 32-bit register port, word index addressing
// Notes: offsets are register indexes
//
// What this block does
// - abort bit self-clears after all aborts
// - requested mode codes, 101 and 110 reserved
// - read-only current mode in same encoding
// - capture enable gates timestamp timer and capture
// - module-on bit enables whole module
// - clearing on waits for transaction, busy shows it
// - unimplemented control bits read zero
// - one byte lane per filter, enable/mask/fifo
// - filter enable turns filter on/off
// - mask select chooses mask 0 to 3
// - fifo select 0 to 15, upper codes reserved
// - mask/fifo writes only while filter disabled
`ifndef CMFC_CONSTS_VH
`define CMFC_CONSTS_VH

// ****************************************
// register indexes
// ****************************************
`define CMFC_IDX_CTRL 4'h0
`define CMFC_IDX_FLT3 4'h1
`define CMFC_IDX_IRQ_STAT 4'h2
`define CMFC_IDX_IRQ_EN 4'h3
`define CMFC_IDX_IRQ_CLR 4'h4
`define CMFC_IDX_TMR 4'h5

// ****************************************
// control field positions
// ****************************************
`define CMFC_ABORT_BIT 27
`define CMFC_REQ_HI 26
`define CMFC_REQ_LO 24
`define CMFC_CUR_HI 23
`define CMFC_CUR_LO 21
`define CMFC_CAP_BIT 20
`define CMFC_ON_BIT 15
`define CMFC_STOP_WHEN_CPU_IDLE_BIT 13
`define CMFC_BUSY_BIT 11
`define CMFC_DEVICENET_COMPARE_COUNT_HI 4
`define CMFC_CTRL_WMASK 32'h0F00201F

// ****************************************
// reset values and modes
// ****************************************
`define CMFC_MODE_NORMAL 3'h0
`define CMFC_MODE_DISABLE 3'h1
`define CMFC_MODE_LOOPBACK 3'h2
`define CMFC_MODE_LISTEN 3'h3
`define CMFC_MODE_CONFIG 3'h4
`define CMFC_MODE_LISTEN_ALL 3'h7
`define CMFC_FLT_RST 16'h0000

// ****************************************
// filter lane layout
// ****************************************
`define CMFC_FLT_EN_BIT 7
`define CMFC_FLT_FSEL_MAX 5'h0F

// ****************************************
// interrupt bits
// ****************************************
`define CMFC_IRQ_ABORT_DONE 0
`define CMFC_IRQ_MODE_CHG 1
`define CMFC_IRQ_OFF_DONE 2
`define CMFC_IRQ_RX_STORED 3

`endif

// ---- logic/cmfc_top.v ----
// Purpose: mode, abort, capture and filter control of a CAN controller
// Assumes: engine signals are on clk_sys
// Notes: filters twelve and thirteen held here
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cmfc_consts.vh"

module cmfc_top (
    input wire clk_sys,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire eng_tx_pending,
    input wire eng_transaction_active,
    input wire eng_mode_ready,
    input wire rx_valid,
    input wire rx_match_twelve,
    input wire rx_match_thirteen,
    output reg abort_request,
    output reg [2:0] engine_mode,
    output reg module_enable,
    output reg timer_run,
    output reg [15:0] receive_timestamp_timer,
    output reg [15:0] rx_timestamp,
    output reg rx_store,
    output reg [3:0] rx_fifo,
    output reg [1:0] filter_twelve_mask_select,
    output reg [1:0] filter_thirteen_mask_select,
    output reg filter_twelve_enable,
    output reg filter_thirteen_enable,
    output reg irq
);

    // ****************************************
    // helpers
    // ****************************************
    function valid_mode;
        input [2:0] m;
        begin
            valid_mode = (m != 3'h5) && (m != 3'h6);
        end
    endfunction

    // lane update honoring the enable lock
    function [7:0] lane_update;
        input [7:0] old_lane;
        input [7:0] new_lane;
        begin
            if (old_lane[`CMFC_FLT_EN_BIT]) begin
                lane_update = {new_lane[7], old_lane[6:0]};
            end else begin
                lane_update = new_lane;
            end
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    reg abort_reg;
    reg [2:0] req_mode_reg;
    reg [2:0] cur_mode_reg;
    reg cap_reg;
    reg on_reg;
    reg stop_when_cpu_idle_reg;
    reg [4:0] devicenet_compare_count_reg;
    reg busy_reg;
    reg [15:0] flt_reg;
    reg [3:0] stat_reg;
    reg [3:0] en_reg;
    reg [3:0] ev_next;
    wire wr_ctrl;
    wire [31:0] ctrl_word;
    wire [7:0] lane12;
    wire [7:0] lane13;
    wire hit12;
    wire hit13;
    wire [2:0] eff_mode;

    assign wr_ctrl = reg_wr && (reg_addr == `CMFC_IDX_CTRL);
    assign lane12 = flt_reg[7:0];
    assign lane13 = flt_reg[15:8];
    assign hit12 = lane12[`CMFC_FLT_EN_BIT] && rx_match_twelve;
    assign hit13 = lane13[`CMFC_FLT_EN_BIT] && rx_match_thirteen;
    assign eff_mode = on_reg ? req_mode_reg : `CMFC_MODE_DISABLE;
    assign ctrl_word = {4'h0, abort_reg, req_mode_reg, cur_mode_reg, cap_reg, 4'h0,
                        on_reg, 1'b0, stop_when_cpu_idle_reg, 1'b0, busy_reg, 3'h0, 3'h0, devicenet_compare_count_reg};

    // ****************************************
    // control register
    // ****************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            abort_reg <= 1'b0;
            req_mode_reg <= `CMFC_MODE_CONFIG;
            cap_reg <= 1'b0;
            on_reg <= 1'b0;
            stop_when_cpu_idle_reg <= 1'b0;
            devicenet_compare_count_reg <= 5'h00;
        end else begin
            if (wr_ctrl) begin
                if (valid_mode(reg_wdata[`CMFC_REQ_HI:`CMFC_REQ_LO])) begin
                    req_mode_reg <= reg_wdata[`CMFC_REQ_HI:`CMFC_REQ_LO];
                end
                cap_reg <= reg_wdata[`CMFC_CAP_BIT];
                on_reg <= reg_wdata[`CMFC_ON_BIT];
                stop_when_cpu_idle_reg <= reg_wdata[`CMFC_STOP_WHEN_CPU_IDLE_BIT];
                devicenet_compare_count_reg <= reg_wdata[`CMFC_DEVICENET_COMPARE_COUNT_HI:0];
            end
            if (wr_ctrl && reg_wdata[`CMFC_ABORT_BIT]) begin
                abort_reg <= 1'b1;
            end else if (abort_reg && !eng_tx_pending) begin
                abort_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // mode tracking and busy
    // ****************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur_mode_reg <= `CMFC_MODE_CONFIG;
            busy_reg <= 1'b0;
            module_enable <= 1'b0;
            engine_mode <= `CMFC_MODE_CONFIG;
            abort_request <= 1'b0;
        end else begin
            abort_request <= abort_reg;
            engine_mode <= eff_mode;
            if (on_reg) begin
                module_enable <= 1'b1;
                busy_reg <= 1'b1;
            end else if (!eng_transaction_active) begin
                module_enable <= 1'b0;
                busy_reg <= 1'b0;
            end
            if (eng_mode_ready && !eng_transaction_active) begin
                cur_mode_reg <= eff_mode;
            end
        end
    end

    // ****************************************
    // timestamp timer and capture
    // ****************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            receive_timestamp_timer <= 16'h0000;
            timer_run <= 1'b0;
            rx_timestamp <= 16'h0000;
            rx_store <= 1'b0;
            rx_fifo <= 4'h0;
        end else begin
            timer_run <= cap_reg && module_enable;
            if (cap_reg && module_enable) begin
                receive_timestamp_timer <= receive_timestamp_timer + 16'h0001;
            end
            rx_store <= rx_valid && module_enable && (hit12 || hit13);
            if (rx_valid && (hit12 || hit13)) begin
                rx_fifo <= hit12 ? lane12[3:0] : lane13[3:0];
                rx_timestamp <= cap_reg ? receive_timestamp_timer : 16'h0000;
            end
        end
    end

    // ****************************************
    // filter control register
    // ****************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flt_reg <= `CMFC_FLT_RST;
        end else if (reg_wr && reg_addr == `CMFC_IDX_FLT3) begin
            flt_reg[7:0] <= lane_update(lane12, reg_wdata[7:0]);
            flt_reg[15:8] <= lane_update(lane13, reg_wdata[15:8]);
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            filter_twelve_enable <= 1'b0;
            filter_thirteen_enable <= 1'b0;
            filter_twelve_mask_select <= 2'h0;
            filter_thirteen_mask_select <= 2'h0;
        end else begin
            filter_twelve_enable <= lane12[`CMFC_FLT_EN_BIT];
            filter_thirteen_enable <= lane13[`CMFC_FLT_EN_BIT];
            filter_twelve_mask_select <= lane12[6:5];
            filter_thirteen_mask_select <= lane13[6:5];
        end
    end

    // ****************************************
    // interrupts
    // ****************************************
    always @* begin
        ev_next = 4'h0;
        ev_next[`CMFC_IRQ_ABORT_DONE] = abort_reg && !eng_tx_pending;
        ev_next[`CMFC_IRQ_MODE_CHG] = eng_mode_ready && !eng_transaction_active && (cur_mode_reg != eff_mode);
        ev_next[`CMFC_IRQ_OFF_DONE] = busy_reg && !on_reg && !eng_transaction_active;
        ev_next[`CMFC_IRQ_RX_STORED] = rx_valid && module_enable && (hit12 || hit13);
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stat_reg <= 4'h0;
            en_reg <= 4'h0;
            irq <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `CMFC_IDX_IRQ_EN) begin
                en_reg <= reg_wdata[3:0];
            end
            if (reg_wr && reg_addr == `CMFC_IDX_IRQ_CLR) begin
                stat_reg <= (stat_reg & ~reg_wdata[3:0]) | ev_next;
            end else begin
                stat_reg <= stat_reg | ev_next;
            end
            irq <= |((stat_reg | ev_next) & en_reg);
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `CMFC_IDX_CTRL: reg_rdata <= ctrl_word;
                `CMFC_IDX_FLT3: reg_rdata <= {16'h0000, flt_reg};
                `CMFC_IDX_IRQ_STAT: reg_rdata <= {28'h0000000, stat_reg};
                `CMFC_IDX_IRQ_EN: reg_rdata <= {28'h0000000, en_reg};
                `CMFC_IDX_TMR: reg_rdata <= {16'h0000, receive_timestamp_timer};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule // cmfc_top
`default_nettype wire

// ---- verif/cmfc_checker.sv ----
// Purpose: port assertions for cmfc_top
// Assumes: one clock, async rst
// Notes: bound after the module
`timescale 1ns/100ps
`default_nettype none
module cmfc_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic eng_tx_pending,
    input wire logic eng_transaction_active,
    input wire logic rx_valid,
    input wire logic rx_match_twelve,
    input wire logic rx_match_thirteen,
    input wire logic abort_request,
    input wire logic [2:0] engine_mode,
    input wire logic module_enable,
    input wire logic timer_run,
    input wire logic [15:0] receive_timestamp_timer,
    input wire logic [15:0] rx_timestamp,
    input wire logic rx_store,
    input wire logic [1:0] filter_twelve_mask_select,
    input wire logic filter_twelve_enable
);
    // ****************
    // port relations
    // ****************
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_cap_off;
        rx_store && !timer_run;
    endsequence
    sequence s_abort_served;
        abort_request && !eng_tx_pending;
    endsequence
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000) else $error("rdata not idle");
    a_unimpl_read_zero: assert property ($past(reg_rd) |-> reg_rdata[31:28] == 4'h0 && reg_rdata[19:16] == 4'h0)
        else $error("unimplemented bits set");
    a_mode_code_legal: assert property (engine_mode != 3'h5 && engine_mode != 3'h6) else $error("reserved mode");
    a_store_has_cause: assert property (rx_store |-> $past(rx_valid && (rx_match_twelve || rx_match_thirteen)))
        else $error("store without match");
    a_stamp_off_zero: assert property (s_cap_off |-> rx_timestamp == 16'h0000) else $error("stamp while off");
    a_timer_frozen: assert property (!timer_run |-> $stable(receive_timestamp_timer))
        else $error("timer moved while stopped");
    a_abort_clears: assert property (s_abort_served |-> ##[1:3] !abort_request) else $error("abort stuck");
    a_off_after_idle: assert property ($fell(module_enable) |->
        !$past(eng_transaction_active) || !$past(eng_transaction_active, 2)) else $error("off mid transaction");
    a_mask_locked: assert property (filter_twelve_enable && $past(filter_twelve_enable) |->
        $stable(filter_twelve_mask_select)) else $error("mask changed while enabled");
endmodule // cmfc_checker
bind cmfc_top cmfc_checker cmfc_checker_i (.clk_sys, .rst, .reg_rd, .reg_rdata, .eng_tx_pending,
    .eng_transaction_active, .rx_valid, .rx_match_twelve, .rx_match_thirteen, .abort_request, .engine_mode,
    .module_enable, .timer_run, .receive_timestamp_timer, .rx_timestamp, .rx_store, .filter_twelve_mask_select,
    .filter_twelve_enable);
`default_nettype wire

// ---- verif/cmfc_engine_model.sv ----
// Purpose: protocol engine stand-in
// Assumes: clk_sys domain
// Notes: SLOW sets abort latency
`timescale 1ns/100ps
`default_nettype none
module cmfc_engine_model #(parameter int SLOW = 4) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic abort_request,
    output logic eng_tx_pending,
    output logic eng_transaction_active,
    output logic eng_mode_ready
);
    // ****************
    // engine behaviour
    // ****************
    int cnt;
    assign eng_tx_pending = !(abort_request && cnt >= SLOW);
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            eng_transaction_active <= 1'b0;
            eng_mode_ready <= 1'b0;
        end else begin
            cnt <= abort_request ? cnt + 1 : 0;
            eng_transaction_active <= ($urandom % 4) == 0;
            eng_mode_ready <= ($urandom % 3) != 0;
        end
    end
endmodule // cmfc_engine_model
`default_nettype wire

// ---- verif/cmfc_top_bench.sv ----
// Purpose: self-checking bench for cmfc_top
// Assumes: engine model on far side
// Notes: expectations kept in ints
`timescale 1ns/100ps
`default_nettype none
module cmfc_top_bench;
    logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_valid = 0, rx_match_twelve = 0, rx_match_thirteen = 0;
    logic [3:0] reg_addr = 0, rx_fifo;
    logic [31:0] reg_wdata = 0, reg_rdata, rd;
    logic [15:0] receive_timestamp_timer, rx_timestamp;
    logic [2:0] engine_mode;
    logic [1:0] filter_twelve_mask_select, filter_thirteen_mask_select;
    logic abort_request, module_enable, timer_run, rx_store, filter_twelve_enable, filter_thirteen_enable, irq;
    logic eng_tx_pending, eng_transaction_active, eng_mode_ready;
    int mismatches = 0, num_checks = 0, flt = 0, req = 4, w, k, got, cap;
    // ****************
    // clock and parts
    // ****************
    always #2.5 clk_sys = ~clk_sys;
    cmfc_top cmfc_top_i (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .eng_tx_pending,
        .eng_transaction_active, .eng_mode_ready, .rx_valid, .rx_match_twelve, .rx_match_thirteen, .abort_request,
        .engine_mode, .module_enable, .timer_run, .receive_timestamp_timer, .rx_timestamp, .rx_store, .rx_fifo,
        .filter_twelve_mask_select, .filter_thirteen_mask_select, .filter_twelve_enable, .filter_thirteen_enable, .irq);
    cmfc_engine_model cmfc_engine_model_i (.clk_sys, .rst, .abort_request, .eng_tx_pending,
        .eng_transaction_active, .eng_mode_ready);
    task automatic print_verdict;
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        rd = reg_rdata;
    endtask
    task automatic poll(input logic [31:0] mask, input logic [31:0] val);
        k = 0;
        do bus(0, 0, 0); while ((rd & mask) !== val && k++ < 20);
    endtask
    initial begin
        k = $urandom(6918);
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        bus(0, 0, 0);
        check("ctrl reset", 32'h04800000, rd);
        for (int m = 0; m < 8; m++) begin
            bus(1, 0, 32'h00008000 | (m << 24));
            if (m != 5 && m != 6) req = m;
            poll(32'h00E00000, req << 21);
            check("mode fields", {req[2:0], req[2:0]}, rd[26:21]);
            check("engine mode", req, engine_mode);
        end
        repeat (4) begin
            w = $urandom & 32'hF3FFFFFF | 32'h00108000;
            bus(1, 0, w);
            bus(0, 0, 0);
            check("ctrl fields", w & 32'h0310A01F, rd & 32'hF71FF7FF);
        end
        check("timer run", 1, timer_run);
        bus(1, 3, 32'hF);
        bus(1, 4, 32'hF);
        bus(1, 0, 32'h08108000);
        poll(32'h08E00000, 0);
        check("abort clear", 0, rd[27]);
        bus(0, 2, 0);
        check("abort event", 1, rd[0]);
        check("irq raised", 1, irq);
        bus(1, 3, 0);
        @(posedge clk_sys);
        check("irq masked", 0, irq);
        bus(1, 4, 32'hF);
        bus(0, 2, 0);
        check("status clear", 0, rd[3:0]);
        repeat (12) begin
            cap = $urandom & 32'h00100000;
            bus(1, 0, 32'h00008000 | cap);
            w = $urandom & 32'h0000EFEF;
            for (k = 0; k < 16; k += 8)
                flt[k +: 8] = flt[k + 7] ? {w[k + 7], flt[k +: 7]} : w[k +: 8];
            bus(1, 1, w);
            bus(0, 1, 0);
            check("filter ctrl", flt, rd);
            check("filter pins", {flt[15:13], flt[7:5]},
                {filter_thirteen_enable, filter_thirteen_mask_select, filter_twelve_enable, filter_twelve_mask_select});
            rx_valid <= 1'b1;
            rx_match_twelve <= 1'($urandom);
            rx_match_thirteen <= 1'($urandom);
            @(posedge clk_sys);
            rx_valid <= 1'b0;
            got = -1;
            repeat (3) begin
                @(posedge clk_sys);
                if (rx_store === 1'b1) begin
                    got = rx_fifo;
                    check("rx stamp", cap ? 16'(receive_timestamp_timer - 16'h0001) : 0, rx_timestamp);
                end
            end
            w = (rx_match_twelve & flt[7]) ? flt[3:0] : (rx_match_thirteen & flt[15]) ? flt[11:8] : -1;
            check("rx fifo", w, got);
        end
        bus(1, 4'hA, $urandom);
        bus(0, 4'hA, 0);
        check("unmapped", 0, rd);
        bus(1, 0, 0);
        poll(32'h00000800, 0);
        check("busy", 0, rd[11]);
        check("module off", 0, module_enable);
        print_verdict;
    end
    initial begin
        #100000;
        mismatches++;
        print_verdict;
    end
endmodule // cmfc_top_bench
`default_nettype wire
